// ==== tb/adc_seq_props.sv ====
// Checker of bus timing and converter output relations
`timescale 1ns/1ns
`default_nettype none
module adc_seq_props
  import adc_ctrl_pkg::*;
#(
  parameter int RES_W = RES_BITS
)(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic irq,
  input wire logic compareBit,
  input wire logic [7:0] analogMuxSel,
  input wire logic [7:0] pinAnalogEn,
  input wire logic converterPowerOn,
  input wire logic sampleActive
);
  int runLen;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  // Length of the current sampling span, frozen with the clock enable
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      runLen <= 0;
    else if (!sampleActive)
      runLen <= 0;
    else if (clkEn)
      runLen <= runLen + 1;
  sequence ack_s;
    !waitrequest ##1 waitrequest;
  endsequence
  sequence rdack_s;
    read && !waitrequest;
  endsequence
  AST_ACK_ONE: assert property ($rose(read | write) |=> ack_s)
    else $error("access not answered by one ack cycle");
  AST_ACK_CAUSE: assert property (!waitrequest |-> $past(read | write))
    else $error("ack without a request");
  AST_LOW_ZERO: assert property (rdack_s and address == 8'h24
    |-> readdata[5:0] == 6'h0 && readdata[31:8] == 24'h0)
    else $error("unused low result bits not zero");
  AST_UNMAPPED: assert property (rdack_s and address > 8'h2A
    |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_POWER_OFF: assert property (!converterPowerOn
    |-> analogMuxSel == 8'h00 && pinAnalogEn == 8'h00)
    else $error("converter off but pins or channel routed");
  AST_PINS_CONTIG: assert property (
    ((pinAnalogEn + 8'h01) & pinAnalogEn) == 8'h00 && $onehot0(analogMuxSel))
    else $error("analog pins not contiguous or channel not one-hot");
  AST_SAMPLE_ON: assert property (sampleActive |-> converterPowerOn)
    else $error("sampling while powered off");
  AST_SAMPLE_LEN: assert property ($fell(sampleActive)
    |-> runLen == 64 || runLen == 256 || runLen == 1024)
    else $error("sampling span not 32 converter clocks");
endmodule
bind adc_sequencer_control adc_seq_props #(.RES_W(RES_W)) props (
  .clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn), .address(address),
  .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .irq(irq), .compareBit(compareBit),
  .analogMuxSel(analogMuxSel), .pinAnalogEn(pinAnalogEn),
  .converterPowerOn(converterPowerOn), .sampleActive(sampleActive));
`default_nettype wire

// ==== tb/analog_source.sv ====
// Analog input model: a fixed level per channel, answered bit by bit
`timescale 1ns/1ns
`default_nettype none
module analog_source (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sampleActive,
  input wire logic [7:0] analogMuxSel,
  input wire logic [7:0] tadLen,
  output logic compareBit
);
  int cyc;
  int idx;
  logic busy;
  logic tog;
  logic [9:0] lvl;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      cyc <= 0;
      busy <= 1'b0;
      tog <= 1'b0;
    end
    else
    begin
      tog <= ~tog;
      cyc <= sampleActive ? 0 : cyc + 1;
      busy <= sampleActive || (busy && cyc < 10 * tadLen);
    end
  // level chosen by the routed channel
  always_comb
  begin
    lvl = 10'h2C9;
    for (int c = 0; c < 8; c++)
      if (analogMuxSel[c])
        lvl = 10'h2C9 ^ {c[2:0], c[2:0], c[2:0], 1'b0};
    // Bit k stands from just after the edge taking bit k-1 up to its own
    idx = (cyc + 1) / tadLen;
  end
  // Outside a conversion the comparator output is meaningless, so toggle
  assign compareBit = (busy && idx < 10) ? lvl[9 - idx] : tog;
endmodule
`default_nettype wire

// ==== tb/test_adc_sequencer_control.sv ====
// Register-level testbench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module test_adc_sequencer_control;
  import adc_ctrl_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, read = 1'b0, write = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0, readdata;
  logic waitrequest, irq, compareBit, converterPowerOn, sampleActive;
  logic [7:0] analogMuxSel, pinAnalogEn, rv;
  logic [9:0] lv;
  logic [7:0] tadLen = 8'h08;
  int err_total = 0;
  int check_count = 0;
  adc_sequencer_control dut (.clk_sys(clk_sys), .resetn(resetn),
    .clkEn(1'b1), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .compareBit(compareBit), .analogMuxSel(analogMuxSel),
    .pinAnalogEn(pinAnalogEn), .converterPowerOn(converterPowerOn),
    .sampleActive(sampleActive));
  analog_source src (.clk_sys(clk_sys), .resetn(resetn),
    .sampleActive(sampleActive), .analogMuxSel(analogMuxSel),
    .tadLen(tadLen), .compareBit(compareBit));
  initial forever #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held until the edge that samples waitrequest low
  task automatic acc(input logic w, input logic [7:0] a, d);
    int n = 0;
    @(posedge clk_sys);
    address <= a;
    writedata <= {24'h0, d};
    read <= !w;
    write <= w;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rv = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    chk("ack", n < 20, 1'b1);
  endtask
  task automatic settle;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic conv(input logic [2:0] ch, input logic [1:0] sel,
                      input logic [7:0] tad);
    int n = 0;
    tadLen = tad;
    lv = 10'h2C9 ^ {ch, ch, ch, 1'b0};
    acc(1, OFS_CLOCK_SEL, {6'h0, sel});
    acc(1, OFS_IRQ_CLEAR, 8'h03);
    // config and start bit written in one access
    acc(1, OFS_CONTROL, {2'b10, 3'd4, ch});
    acc(0, OFS_CONTROL, 0);
    chk("flag set", rv[DONE_N_BIT], 1'b1);
    acc(0, OFS_IRQ_STATUS, 0);
    chk("start status", rv, 8'h02);
    acc(1, OFS_CONTROL, {2'b00, 3'd4, ch});
    repeat (70 * tad) @(posedge clk_sys);
    acc(0, OFS_CONTROL, 0);
    chk("flag early", rv[DONE_N_BIT], 1'b1);
    // poll until the flag reads zero; each read takes three cycles
    do
    begin
      acc(0, OFS_CONTROL, 0);
      n++;
    end while (rv[DONE_N_BIT] !== 1'b0 && n < 100);
    chk("flag clear", rv[DONE_N_BIT], 1'b0);
    chk("polls", n, 32'((CONV_TADS - 70) * tad / 3));
    acc(0, OFS_RESULT_HIGH, 0);
    chk("high", rv, lv[9:2]);
    acc(0, OFS_RESULT_LOW, 0);
    chk("low", rv, {lv[1:0], 6'h00});
    chk("irq", irq, 1'b1);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    // Run needs about 3,400 cycles; about six times that marks a hang
    repeat (20000) @(posedge clk_sys);
    err_total++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    acc(0, OFS_CONTROL, 0);
    chk("ctl reset", rv, CONTROL_RESET);
    acc(0, OFS_CLOCK_SEL, 0);
    chk("clk reset", rv[1:0], CLKSEL_RESET);
    acc(0, 8'h40, 0);
    chk("unmapped", rv, 8'h00);
    acc(1, OFS_CLOCK_SEL, 8'h01);
    acc(0, OFS_CLOCK_SEL, 0);
    chk("clk sel", rv[1:0], CLK_DIV8);
    acc(1, OFS_CONTROL, 8'h20);
    settle();
    chk("pins", {pinAnalogEn, analogMuxSel}, 16'h0F01);
    for (int c = 0; c < 8; c++)
    begin
      acc(1, OFS_CONTROL, {2'b00, 3'd7, c[2:0]});
      settle();
      chk("mux", {pinAnalogEn, analogMuxSel}, {8'hFF, 8'h01 << c});
    end
    acc(1, OFS_CONTROL, 8'h05);
    settle();
    chk("off", {converterPowerOn, pinAnalogEn}, 9'h000);
    acc(1, OFS_IRQ_ENABLE, 8'h03);
    conv(3'd3, CLK_DIV8, 8);
    conv(3'd6, CLK_DIV2, 2);
    conv(3'd0, CLK_DIV32, 32);
    acc(1, OFS_RESULT_HIGH, 8'hA5);
    acc(0, OFS_RESULT_HIGH, 0);
    chk("ro high", rv, lv[9:2]);
    acc(1, OFS_IRQ_ENABLE, 8'h00);
    settle();
    chk("masked", irq, 1'b0);
    acc(1, OFS_IRQ_ENABLE, 8'h01);
    settle();
    chk("unmask", irq, 1'b1);
    acc(1, OFS_IRQ_CLEAR, 8'h03);
    acc(0, OFS_IRQ_STATUS, 0);
    chk("cleared", {irq, rv}, 9'h000);
    close_out();
  end
endmodule
`default_nettype wire

// ==== verilog/adc_ctrl_pkg.sv ====
// Constants for the converter sequencer control block
// Function
// - Channel code 000..111 routes analog input zero..seven to converter.
// - Result left-justified: bits 9..2 in high byte, 1..0 in low 7..6.
// - Start high resets converter; start falling begins a conversion.
// - Converter clock is sys/2, /8 or /32; sample 32, convert 44, 76 clocks in all.
// - Writing 0000_0001 to clock select register picks sys/8.
// - Writing 0010_0000 to control makes pins 0..3 analog, channel zero.
// - Start rising edge resets converter and sets flag; finish clears it.
// - Control: channel bits 2..0, config 5..3, flag 6, start 7.
// - Config zero: all pins digital, converter off; analog pins lose digital.
// - Clock select codes 00, 01, 10 give sys/2, /8, /32; 11 undefined.
package adc_ctrl_pkg;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h24;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h25;
  localparam logic [7:0] OFS_CONTROL = 8'h26;
  localparam logic [7:0] OFS_CLOCK_SEL = 8'h27;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h29;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h2A;
  localparam int CH_LSB = 0;
  localparam int CFG_LSB = 3;
  localparam int DONE_N_BIT = 6;
  localparam int START_BIT = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] CLKSEL_RESET = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV8 = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [4:0] HALF_DIV2 = 5'h00;
  localparam logic [4:0] HALF_DIV8 = 5'h03;
  localparam logic [4:0] HALF_DIV32 = 5'h0F;
  localparam int SAMPLE_TADS = 32;
  localparam int CONV_TADS = 76;
  localparam int RES_BITS = 10;
  typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_SAMPLE, ST_CONVERT}
    conv_state_e;
endpackage

// ==== verilog/adc_sequencer_control.sv ====
// Converter sequencer: registers, clock divider, sequencing and result
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_control
  import adc_ctrl_pkg::*;
#(
  parameter int RES_W = RES_BITS
)(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  // Comparator decision from the analog array, one bit per converter clock
  input wire logic compareBit,
  output logic [7:0] analogMuxSel,
  output logic [7:0] pinAnalogEn,
  output logic converterPowerOn,
  output logic sampleActive
);

  //////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, answer at the second edge
  // A request still high while ack_q is set is the one being answered,
  // so the master must drop it at that edge or it is taken again
  logic ack_q;
  logic access;
  logic wrHit;
  assign access = (read | write) & ~ack_q;
  assign wrHit = write & ack_q;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      ack_q <= 1'b0;
    else if (clkEn)
      ack_q <= access;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      waitrequest <= 1'b1;
    else if (clkEn)
      waitrequest <= ~access;
  end

  //////////////////////////////////////////////////////////////////////////
  // Control and clock select registers
  logic [2:0] chanSel_q;
  logic [2:0] pinCfg_q;
  logic startBit_q;
  logic startPrev_q;
  logic doneN_q;
  logic [1:0] clkSel_q;
  logic [RES_W-1:0] result_q;
  logic [1:0] irqStat_q;
  logic [1:0] irqEn_q;
  logic startRise;
  logic startFall;
  logic convFinish;
  conv_state_e state_q;

  assign startRise = startBit_q & ~startPrev_q;
  assign startFall = ~startBit_q & startPrev_q;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      chanSel_q <= CONTROL_RESET[CH_LSB +: 3];
      pinCfg_q <= CONTROL_RESET[CFG_LSB +: 3];
      startBit_q <= CONTROL_RESET[START_BIT];
    end
    else if (clkEn && wrHit && address == OFS_CONTROL)
    begin
      chanSel_q <= writedata[CH_LSB +: 3];
      pinCfg_q <= writedata[CFG_LSB +: 3];
      startBit_q <= writedata[START_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      clkSel_q <= CLKSEL_RESET;
    else if (clkEn && wrHit && address == OFS_CLOCK_SEL)
      clkSel_q <= writedata[1:0];
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      startPrev_q <= 1'b0;
    else if (clkEn)
      startPrev_q <= startBit_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // Converter clock divider
  logic [4:0] divCnt_q;
  logic [4:0] halfCount;
  logic tadPhase_q;
  logic tadTick;

  // Undefined code 11 falls to the slowest rate, the safe choice
  // divide by 2, 8 or 32; code 11 treated as /32
  always_comb
  begin
    unique case (clkSel_q)
      CLK_DIV2: halfCount = HALF_DIV2;
      CLK_DIV8: halfCount = HALF_DIV8;
      default: halfCount = HALF_DIV32;
    endcase
  end

  assign tadTick = (divCnt_q == halfCount) & tadPhase_q;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      divCnt_q <= 5'h00;
      tadPhase_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (state_q == ST_IDLE || state_q == ST_RESET)
      begin
        divCnt_q <= 5'h00;
        tadPhase_q <= 1'b0;
      end
      else if (divCnt_q == halfCount)
      begin
        divCnt_q <= 5'h00;
        tadPhase_q <= ~tadPhase_q;
      end
      else
        divCnt_q <= divCnt_q + 5'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  logic [6:0] tadCnt_q;
  logic [RES_W-1:0] sar_q;
  logic [3:0] bitIdx_q;

  // Config at zero parks the sequencer; a later config write does not
  // restart it, software has to pulse start again
  // start high holds reset, falling edge begins
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state_q <= ST_IDLE;
    else if (clkEn)
    begin
      if (startBit_q || pinCfg_q == 3'h0)
        state_q <= startBit_q ? ST_RESET : ST_IDLE;
      else if (startFall)
        state_q <= ST_SAMPLE;
      else if (tadTick && state_q == ST_SAMPLE &&
               tadCnt_q == 7'(SAMPLE_TADS - 1))
        state_q <= ST_CONVERT;
      else if (convFinish)
        state_q <= ST_IDLE;
    end
  end

  // conversion spans 76 converter clocks overall
  assign convFinish = tadTick && state_q == ST_CONVERT &&
                      tadCnt_q == 7'(CONV_TADS - 1);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      tadCnt_q <= 7'h00;
    else if (clkEn)
    begin
      if (state_q == ST_IDLE || state_q == ST_RESET)
        tadCnt_q <= 7'h00;
      else if (tadTick)
        tadCnt_q <= tadCnt_q + 7'h01;
    end
  end

  // Successive approximation, MSB first, one bit per converter clock
  // Only the first ten converter clocks of the conversion phase take
  // bits; the remaining 34 of its 44 are settling time
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sar_q <= '0;
      bitIdx_q <= 4'h0;
    end
    else if (clkEn)
    begin
      if (state_q != ST_CONVERT)
      begin
        sar_q <= '0;
        bitIdx_q <= 4'(RES_W - 1);
      end
      else if (tadTick && tadCnt_q >= 7'(SAMPLE_TADS) &&
               tadCnt_q < 7'(SAMPLE_TADS + RES_W))
      begin
        sar_q[bitIdx_q] <= compareBit;
        bitIdx_q <= bitIdx_q - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    // A cut conversion never loads, so the last result stays readable
    if (!resetn)
      result_q <= '0;
    else if (clkEn && convFinish)
      result_q <= sar_q;
  end

  // Flag resets to zero: nothing pending until a start is seen
  // start rise sets flag, finish clears it
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      doneN_q <= 1'b0;
    else if (clkEn)
    begin
      if (startRise)
        doneN_q <= 1'b1;
      else if (convFinish)
        doneN_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupts: bit0 conversion done, bit1 start reset seen
  logic [1:0] irqEvent;
  logic [1:0] irqClr;
  logic [1:0] irqStat_d;
  assign irqEvent = {startRise, convFinish};
  assign irqStat_d = (irqStat_q & ~irqClr) | irqEvent;
  assign irqClr = (wrHit && address == OFS_IRQ_CLEAR) ? writedata[1:0]
                                                      : 2'h0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      irqStat_q <= 2'h0;
    else if (clkEn)
      irqStat_q <= irqStat_d;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      irqEn_q <= 2'h0;
    else if (clkEn && wrHit && address == OFS_IRQ_ENABLE)
      irqEn_q <= writedata[1:0];
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else if (clkEn)
      // Follow the next status so irq rises with the sticky bit itself
      irq <= |(irqStat_d & irqEn_q);
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [31:0] rdMux;

  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (address)
      // left-justified result, low six bits zero
      OFS_RESULT_LOW: rdMux[7:6] = result_q[1:0];
      OFS_RESULT_HIGH: rdMux[7:0] = result_q[RES_W-1:2];
      OFS_CONTROL: rdMux[7:0] = {startBit_q, doneN_q, pinCfg_q, chanSel_q};
      OFS_CLOCK_SEL: rdMux[1:0] = clkSel_q;
      OFS_IRQ_STATUS: rdMux[1:0] = irqStat_q;
      OFS_IRQ_ENABLE: rdMux[1:0] = irqEn_q;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      readdata <= 32'h0000_0000;
    else if (clkEn)
      // Read data stands only in the answer cycle; zero otherwise keeps
      // stale bytes off the bus
      readdata <= (read && access) ? rdMux : 32'h0000_0000;
  end

  //////////////////////////////////////////////////////////////////////////
  // Analog side outputs
  genvar gi;
  logic [7:0] muxD;
  logic [7:0] pinD;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      assign muxD[gi] = (chanSel_q == 3'(gi)) && (pinCfg_q != 3'h0);
      // pins below config code are analog; code 7 makes all eight analog
      assign pinD[gi] = (pinCfg_q != 3'h0) && (3'(gi) < pinCfg_q ||
                        (pinCfg_q == 3'h7 && gi == 7));
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      analogMuxSel <= 8'h00;
      pinAnalogEn <= 8'h00;
      converterPowerOn <= 1'b0;
      sampleActive <= 1'b0;
    end
    else if (clkEn)
    begin
      analogMuxSel <= muxD;
      pinAnalogEn <= pinD;
      // converter off when no pin is analog
      converterPowerOn <= pinCfg_q != 3'h0;
      // Drop with the power so no sampling shows on a dead converter
      sampleActive <= state_q == ST_SAMPLE && pinCfg_q != 3'h0;
    end
  end

endmodule
`default_nettype wire
